//--- logic/fpg_top.sv
// Frame pulse groups A and B with programmed output and pin routing.
// Assumes host register strobes and CT bus frame inputs are synchronous
// to CORE_CLK_I; pins resolve their level from the output enables.
`timescale 1ns/1ps

// Functional notes
// R1: Rate 00 floats a group's pins; 01, 10, 11 pick 2, 4, 8 Mbit/s bits. Split routing enables A pins 6-11 from B's rate, not A's.
// R2: Pulse type gives widths of one bit, two bits, one byte or two bytes.
// R3: Polarity clear gives normal pulses and set gives inverted ones.
// R4: The twelve outputs pulse in order, eight bit times apart.
// R5: Two-byte pulses overlap their neighbours and nothing suppresses that.
// R6: Start is 11 bits: three high control bits over an 8-bit low register.
// R7: One start step is one 16.384 MHz tick, spanning a whole 125 us frame.
// R8: The frame boundary is frame signal low while the 8 MHz clock rises.
// R9: With zero offset the first output rises at the frame boundary.
// R10: Programmed A is low start bits, then high start bits, then polarity.
// R11: Programmed B is its own low register under the routing low nibble.
// R12: A routing picks A pulses or A bits, alone or with B 0-5 on pins 6-11.
// R13: B routing bit clear picks B pulses; set picks programmed B bits.
// R14: Programmed outputs float at rate 00 and rate does nothing else there.
// R15: Pulse type is ignored for programmed outputs.
// R16: Group B has its own rate, type, polarity and start, coded alike.
// R17: The reserved routing bit reads zero and every register reads back.
module fpg_top
	import fpg_pkg::*;
(
	// Clock and reset
	input wire logic CORE_CLK_I,
	input wire logic RST_B_I,
	// Host register port
	input wire logic [7:0] HOST_ADDR_I,
	input wire logic HOST_WR_I,
	input wire logic [7:0] HOST_WDATA_I,
	input wire logic HOST_RD_I,
	output logic [7:0] HOST_RDATA_O,
	// CT bus frame reference
	input wire logic CT_FRAME_B_I,
	input wire logic CT_C8_I,
	// Group A pins
	output logic [NPULSE-1:0] A_PIN_O,
	output logic [NPULSE-1:0] A_OE_O,
	// Group B pins
	output logic [NPULSE-1:0] B_PIN_O,
	output logic [NPULSE-1:0] B_OE_O
);

	logic [7:0] a_low_reg;
	fpg_hi_t a_hi_reg;
	logic [7:0] b_low_reg;
	fpg_hi_t b_hi_reg;
	logic [7:0] b_prog_reg;
	fpg_route_t route_reg;
	logic [7:0] rdata_reg;
	logic c8_q_reg;
	logic [ACC_W-1:0] acc_reg;
	logic [POS_W-1:0] pos_reg;
	logic [NPULSE-1:0] a_pin_reg;
	logic [NPULSE-1:0] a_oe_reg;
	logic [NPULSE-1:0] b_pin_reg;
	logic [NPULSE-1:0] b_oe_reg;

	// Host decode
	wire wr_a_low = HOST_WR_I && (HOST_ADDR_I == OFS_A_LOW);
	wire wr_a_hi = HOST_WR_I && (HOST_ADDR_I == OFS_A_HI);
	wire wr_b_low = HOST_WR_I && (HOST_ADDR_I == OFS_B_LOW);
	wire wr_b_hi = HOST_WR_I && (HOST_ADDR_I == OFS_B_HI);
	wire wr_b_prog = HOST_WR_I && (HOST_ADDR_I == OFS_B_PROG);
	wire wr_route = HOST_WR_I && (HOST_ADDR_I == OFS_ROUTE);
	logic [7:0] rd_mux;

	assign rd_mux = (HOST_ADDR_I == OFS_A_LOW) ? a_low_reg :
		(HOST_ADDR_I == OFS_A_HI) ? a_hi_reg :
		(HOST_ADDR_I == OFS_B_LOW) ? b_low_reg :
		(HOST_ADDR_I == OFS_B_HI) ? b_hi_reg :
		(HOST_ADDR_I == OFS_B_PROG) ? b_prog_reg :
		(HOST_ADDR_I == OFS_ROUTE) ? route_reg : 8'h00; // R17

	// Frame boundary and 16.384 MHz tick
	wire boundary = !CT_FRAME_B_I && CT_C8_I && !c8_q_reg; // R8
	logic [ACC_W:0] acc_sum;
	assign acc_sum = {1'b0, acc_reg} + {1'b0, TICK_INC};
	// Fractional divider: the tick jitters by one core cycle, far below
	// one 61 ns step
	wire tick = acc_sum[ACC_W]; // R7
	logic [ACC_W-1:0] acc_next;
	logic [POS_W-1:0] pos_next;
	assign acc_next = boundary ? '0 : acc_sum[ACC_W-1:0];
	assign pos_next = boundary ? '0 :
		(tick ? POS_W'(pos_reg + 1'b1) : pos_reg); // R9

	// Group settings
	fpg_grp_t a_cfg;
	fpg_grp_t b_cfg;
	assign a_cfg = '{rate: a_hi_reg.rate, ptype: a_hi_reg.ptype,
		invert: a_hi_reg.invert, start: {a_hi_reg.start_hi, a_low_reg}}; // R6
	assign b_cfg = '{rate: b_hi_reg.rate, ptype: b_hi_reg.ptype,
		invert: b_hi_reg.invert, start: {b_hi_reg.start_hi, b_low_reg}}; // R16

	logic [NPULSE-1:0] a_wave;
	logic [NPULSE-1:0] b_wave;

	fpg_sequencer u_seq_a (
		.clk_i(CORE_CLK_I),
		.rst_b_i(RST_B_I),
		.cfg_i(a_cfg),
		.pos_i(pos_reg),
		.wave_o(a_wave)
	);

	fpg_sequencer u_seq_b (
		.clk_i(CORE_CLK_I),
		.rst_b_i(RST_B_I),
		.cfg_i(b_cfg),
		.pos_i(pos_reg),
		.wave_o(b_wave)
	);

	// Programmed words take no pulse type
	logic [NPULSE-1:0] a_prog;
	logic [NPULSE-1:0] b_prog;
	assign a_prog = {a_hi_reg.invert, a_hi_reg.start_hi, a_low_reg}; // R10 R15
	assign b_prog = {route_reg.prog_hi, b_prog_reg}; // R11 R15

	// Rate only gates the enables in programmed modes
	wire a_on = (a_hi_reg.rate != RATE_OFF); // R1 R14
	wire b_on = (b_hi_reg.rate != RATE_OFF); // R1 R14

	// Pin routing
	logic [NPULSE-1:0] a_val;
	logic [NPULSE-1:0] a_en;
	assign a_val = (route_reg.a_route == ROUTE_A_PULSE) ? a_wave :
		(route_reg.a_route == ROUTE_A_PROG) ? a_prog :
		(route_reg.a_route == ROUTE_A_SPLIT) ? {b_wave[5:0], a_wave[5:0]} :
		{b_wave[5:0], a_prog[5:0]}; // R12
	assign a_en = (route_reg.a_route[1]) ? {{6{b_on}}, {6{a_on}}} :
		{NPULSE{a_on}}; // R12 R14
	wire [NPULSE-1:0] b_val = route_reg.b_route ? b_prog : b_wave; // R13

	always_ff @(posedge CORE_CLK_I) begin
		if (!RST_B_I) begin
			a_low_reg <= RST_LOW;
			a_hi_reg <= RST_HI;
			b_low_reg <= RST_LOW;
			b_hi_reg <= RST_HI;
			b_prog_reg <= RST_LOW;
			route_reg <= RST_ROUTE;
		end else begin
			if (wr_a_low) begin
				a_low_reg <= HOST_WDATA_I;
			end
			if (wr_a_hi) begin
				a_hi_reg <= HOST_WDATA_I;
			end
			if (wr_b_low) begin
				b_low_reg <= HOST_WDATA_I;
			end
			if (wr_b_hi) begin
				b_hi_reg <= HOST_WDATA_I;
			end
			if (wr_b_prog) begin
				b_prog_reg <= HOST_WDATA_I;
			end
			if (wr_route) begin
				route_reg <= HOST_WDATA_I & ROUTE_WMASK; // R17
			end
		end
	end

	always_ff @(posedge CORE_CLK_I) begin
		if (!RST_B_I) begin
			rdata_reg <= 8'h00;
		end else if (HOST_RD_I) begin
			rdata_reg <= rd_mux;
		end
	end

	always_ff @(posedge CORE_CLK_I) begin
		if (!RST_B_I) begin
			c8_q_reg <= 1'b0;
			acc_reg <= '0;
			pos_reg <= '0;
		end else begin
			c8_q_reg <= CT_C8_I;
			acc_reg <= acc_next;
			pos_reg <= pos_next;
		end
	end

	always_ff @(posedge CORE_CLK_I) begin
		if (!RST_B_I) begin
			a_pin_reg <= '0;
			a_oe_reg <= '0;
			b_pin_reg <= '0;
			b_oe_reg <= '0;
		end else begin
			a_pin_reg <= a_val;
			a_oe_reg <= a_en;
			b_pin_reg <= b_val;
			b_oe_reg <= {NPULSE{b_on}};
		end
	end

	assign HOST_RDATA_O = rdata_reg;
	assign A_PIN_O = a_pin_reg;
	assign A_OE_O = a_oe_reg;
	assign B_PIN_O = b_pin_reg;
	assign B_OE_O = b_oe_reg;

	// Checks

	// Cycles since the last tick; saturates so reset cannot fake a gap
	logic [3:0] tick_gap_reg;
	always_ff @(posedge CORE_CLK_I) begin
		if (!RST_B_I) begin
			tick_gap_reg <= 4'hf;
		end else if (tick) begin
			tick_gap_reg <= 4'h0;
		end else if (tick_gap_reg != 4'hf) begin
			tick_gap_reg <= tick_gap_reg + 4'h1;
		end
	end

	property p_a_disabled;
		@(posedge CORE_CLK_I) disable iff (!RST_B_I)
		(a_hi_reg.rate == RATE_OFF) && !route_reg.a_route[1] && !HOST_WR_I
		|=> (A_OE_O == '0);
	endproperty
	a_a_disabled: assert property (p_a_disabled) // R1
		else $error("A pins driven while disabled");

	property p_b_disabled;
		@(posedge CORE_CLK_I) disable iff (!RST_B_I)
		(b_hi_reg.rate == RATE_OFF) |=> (B_OE_O == '0);
	endproperty
	a_b_disabled: assert property (p_b_disabled) // R16
		else $error("B pins driven while disabled");

	property p_a_prog;
		@(posedge CORE_CLK_I) disable iff (!RST_B_I)
		(route_reg.a_route == ROUTE_A_PROG) && a_on
		|=> (A_PIN_O == $past(a_prog)) && (A_OE_O == '1);
	endproperty
	a_a_prog: assert property (p_a_prog) // R10
		else $error("A programmed word wrong");

	property p_b_prog;
		@(posedge CORE_CLK_I) disable iff (!RST_B_I)
		route_reg.b_route && b_on
		|=> (B_PIN_O == {$past(route_reg.prog_hi), $past(b_prog_reg)});
	endproperty
	a_b_prog: assert property (p_b_prog) // R11
		else $error("B programmed word wrong");

	property p_a_pulse;
		@(posedge CORE_CLK_I) disable iff (!RST_B_I)
		(route_reg.a_route == ROUTE_A_PULSE) |=> (A_PIN_O == $past(a_wave));
	endproperty
	a_a_pulse: assert property (p_a_pulse) // R12
		else $error("A pins lost A pulses");

	property p_split;
		@(posedge CORE_CLK_I) disable iff (!RST_B_I)
		(route_reg.a_route == ROUTE_A_SPLIT)
		|=> (A_PIN_O[11:6] == $past(b_wave[5:0])) &&
			(A_OE_O[11:6] == {6{$past(b_on)}});
	endproperty
	a_split: assert property (p_split) // R12
		else $error("B pulses not on A pins 6-11");

	property p_prog_split;
		@(posedge CORE_CLK_I) disable iff (!RST_B_I)
		(route_reg.a_route == ROUTE_A_PROG_SPLIT)
		|=> (A_PIN_O[5:0] == $past(a_low_reg[5:0])) &&
			(A_PIN_O[11:6] == $past(b_wave[5:0]));
	endproperty
	a_prog_split: assert property (p_prog_split) // R12
		else $error("Programmed split routing wrong");

	property p_b_pulse;
		@(posedge CORE_CLK_I) disable iff (!RST_B_I)
		!route_reg.b_route |=> (B_PIN_O == $past(b_wave));
	endproperty
	a_b_pulse: assert property (p_b_pulse) // R13
		else $error("B pins lost B pulses");

	property p_boundary;
		@(posedge CORE_CLK_I) disable iff (!RST_B_I)
		boundary |=> (pos_reg == '0) ##1 (pos_reg <= POS_W'(1));
	endproperty
	a_boundary: assert property (p_boundary) // R8
		else $error("Frame position not restarted");

	property p_tick_gap;
		@(posedge CORE_CLK_I) disable iff (!RST_B_I)
		tick |-> (tick_gap_reg >= 4'hb);
	endproperty
	a_tick_gap: assert property (p_tick_gap) // R7
		else $error("Tick faster than 16.384 MHz");

	property p_pos_hold;
		@(posedge CORE_CLK_I) disable iff (!RST_B_I)
		!tick && !boundary |=> $stable(pos_reg);
	endproperty
	a_pos_hold: assert property (p_pos_hold) // R7
		else $error("Frame position moved without a tick");

	property p_rsvd;
		@(posedge CORE_CLK_I) disable iff (!RST_B_I)
		HOST_RD_I && (HOST_ADDR_I == OFS_ROUTE)
		|=> (HOST_RDATA_O[ROUTE_RSVD_BIT] == 1'b0);
	endproperty
	a_rsvd: assert property (p_rsvd) // R17
		else $error("Reserved routing bit reads one");

	property p_unmapped;
		@(posedge CORE_CLK_I) disable iff (!RST_B_I)
		HOST_RD_I && ((HOST_ADDR_I < OFS_A_LOW) || (HOST_ADDR_I > OFS_ROUTE))
		|=> (HOST_RDATA_O == 8'h00);
	endproperty
	a_unmapped: assert property (p_unmapped) // R17
		else $error("Unmapped address reads nonzero");

	property p_read_prog;
		@(posedge CORE_CLK_I) disable iff (!RST_B_I)
		HOST_RD_I && (HOST_ADDR_I == OFS_B_PROG)
		|=> (HOST_RDATA_O == $past(b_prog_reg));
	endproperty
	a_read_prog: assert property (p_read_prog) // R17
		else $error("B programmed low register misread");

	property p_zero_offset;
		@(posedge CORE_CLK_I) disable iff (!RST_B_I)
		boundary && a_on && (a_cfg.start == '0) && !HOST_WR_I
		|-> ##2 (a_wave[0] == !$past(a_hi_reg.invert, 2));
	endproperty
	a_zero_offset: assert property (p_zero_offset) // R9
		else $error("First pulse not at boundary");

	c_prog_a: cover property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
		(route_reg.a_route == ROUTE_A_PROG) && a_on);
	c_overlap: cover property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
		a_wave[0] && a_wave[1] && !a_hi_reg.invert);
	c_last_pulse: cover property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
		b_wave[11] && b_on && !b_hi_reg.invert);
	c_boundary: cover property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
		boundary);

endmodule

//--- logic/fpg_pkg.sv
// Package for the frame pulse groups: register offsets, field layouts,
// reset values, rate and routing encodings, tick timing constants.
// Assumes a single 200 MHz core clock and byte-wide host registers.
package fpg_pkg;

	// Clock rates and the internal 16.384 MHz tick
	localparam int unsigned CORE_CLK_KHZ = 200000;
	localparam int unsigned TICK_KHZ = 16384;
	localparam int unsigned ACC_W = 16;
	localparam logic [15:0] TICK_INC = 16'((TICK_KHZ * 65536) / CORE_CLK_KHZ);
	localparam int unsigned POS_W = 11;
	localparam int unsigned NPULSE = 12;

	// Register offsets
	localparam logic [7:0] OFS_A_LOW = 8'h20;
	localparam logic [7:0] OFS_A_HI = 8'h21;
	localparam logic [7:0] OFS_B_LOW = 8'h22;
	localparam logic [7:0] OFS_B_HI = 8'h23;
	localparam logic [7:0] OFS_B_PROG = 8'h24;
	localparam logic [7:0] OFS_ROUTE = 8'h25;

	// Reset values and write mask
	localparam logic [7:0] RST_LOW = 8'h00;
	localparam logic [7:0] RST_HI = 8'h00;
	localparam logic [7:0] RST_ROUTE = 8'h00;
	localparam logic [7:0] ROUTE_WMASK = 8'hdf;
	localparam int unsigned ROUTE_RSVD_BIT = 5;

	typedef enum logic [1:0] {
		RATE_OFF,
		RATE_2M,
		RATE_4M,
		RATE_8M
	} fpg_rate_t;

	typedef enum logic [1:0] {
		ROUTE_A_PULSE,
		ROUTE_A_PROG,
		ROUTE_A_SPLIT,
		ROUTE_A_PROG_SPLIT
	} fpg_aroute_t;

	// High control register layout, bit 7 down to bit 0
	typedef struct packed {
		fpg_rate_t rate;
		logic [1:0] ptype;
		logic invert;
		logic [2:0] start_hi;
	} fpg_hi_t;

	// Routing and programmed high register layout
	typedef struct packed {
		fpg_aroute_t a_route;
		logic rsvd;
		logic b_route;
		logic [3:0] prog_hi;
	} fpg_route_t;

	// Settings that one group sequencer needs
	typedef struct packed {
		fpg_rate_t rate;
		logic [1:0] ptype;
		logic invert;
		logic [POS_W-1:0] start;
	} fpg_grp_t;

	// Log2 of one bit time in ticks: 8, 4 or 2 ticks
	function automatic logic [1:0] bit_shift(input fpg_rate_t rate);
		case (rate)
			RATE_2M: bit_shift = 2'h3;
			RATE_4M: bit_shift = 2'h2;
			default: bit_shift = 2'h1;
		endcase
	endfunction

	// Pulse width in bits: 1, 2, 8 or 16
	function automatic logic [4:0] width_bits(input logic [1:0] ptype);
		case (ptype)
			2'h0: width_bits = 5'h01;
			2'h1: width_bits = 5'h02;
			2'h2: width_bits = 5'h08;
			default: width_bits = 5'h10;
		endcase
	endfunction

endpackage

//--- logic/fpg_sequencer.sv
// One framing group sequencer: twelve pulses in order after a start offset.
// Assumes the frame position counts 16.384 MHz ticks from the boundary.
`timescale 1ns/1ps
module fpg_sequencer
	import fpg_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Settings and frame position
	input wire fpg_grp_t cfg_i,
	input wire logic [POS_W-1:0] pos_i,
	// Pulse train, polarity applied
	output logic [NPULSE-1:0] wave_o
);

	logic [POS_W-1:0] rel;
	logic [1:0] sh;
	logic [11:0] wid;
	logic [NPULSE-1:0] active;
	logic [NPULSE-1:0] wave_reg;

	assign rel = pos_i - cfg_i.start; // R6 R7
	assign sh = bit_shift(cfg_i.rate); // R1
	assign wid = 12'({7'h00, width_bits(cfg_i.ptype)} << sh); // R2

	genvar k;
	generate
		for (k = 0; k < NPULSE; k++) begin : g_pulse
			logic [11:0] base;
			// Eight bit times between pulse starts
			// Shift sum is widened so the 2 Mbit/s case does not wrap
			assign base = 12'(k << ({1'b0, sh} + 3'h3)); // R4
			// Windows are tested independently, so wide pulses overlap
			assign active[k] = ({1'b0, rel} >= base) &&
				({1'b0, rel} < 12'(base + wid)); // R5
		end
	endgenerate

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			wave_reg <= '0;
		end else begin
			wave_reg <= active ^ {NPULSE{cfg_i.invert}}; // R3
		end
	end

	assign wave_o = wave_reg;

endmodule

//--- test/fpg_stream_rx.sv
// Model of the local framed devices listening to twelve frame pulse pins.
// Assumes a pin with its enable low floats, so it shows a changing level.
`timescale 1ns/1ps
module fpg_stream_rx
	import fpg_pkg::*;
(
	// Clock
	input wire logic clk_i,
	// Pins from the framing group
	input wire logic [NPULSE-1:0] pin_i,
	input wire logic [NPULSE-1:0] oe_i,
	// Level each listener sees
	output logic [NPULSE-1:0] level_o
);
	logic [NPULSE-1:0] last_reg = '0;
	// Toggling on floating pins so a held value cannot pass for a drive
	assign level_o = (oe_i & pin_i) | (~oe_i & ~last_reg);
	always @(posedge clk_i) last_reg <= level_o;
endmodule

//--- test/frame_pulse_groups_bench.sv
// Self-checking bench for the frame pulse groups.
// Assumes the host strobes and CT frame inputs are synchronous to the clock.
`timescale 1ns/1ps
module frame_pulse_groups_bench
	import fpg_pkg::*;
;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic frm_b = 1'b1;
	logic c8 = 1'b0;
	logic rd_d = 1'b0;
	logic samp = 1'b0;
	logic [7:0] rdata;
	logic [NPULSE-1:0] a_pin, a_oe, b_pin, b_oe, a_lvl, b_lvl;
	logic [7:0] rd_q[$];
	logic [47:0] pin_q[$];
	logic [7:0] r, h, pl, pb;
	int mismatches = 0;
	int check_count = 0;
	int seed = 77578;

	always #2.5 clk = ~clk;

	fpg_top u_fpg_top (.CORE_CLK_I(clk), .RST_B_I(rst_b),
		.HOST_ADDR_I(addr), .HOST_WR_I(wr), .HOST_WDATA_I(wdata),
		.HOST_RD_I(rd), .HOST_RDATA_O(rdata), .CT_FRAME_B_I(frm_b),
		.CT_C8_I(c8), .A_PIN_O(a_pin), .A_OE_O(a_oe), .B_PIN_O(b_pin),
		.B_OE_O(b_oe));
	fpg_stream_rx u_fpg_stream_rx (.clk_i(clk), .pin_i(a_pin),
		.oe_i(a_oe), .level_o(a_lvl));
	fpg_stream_rx u_fpg_stream_rx_b (.clk_i(clk), .pin_i(b_pin),
		.oe_i(b_oe), .level_o(b_lvl));

	task automatic give_verdict();
		if (mismatches == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic check8(string n, logic [7:0] e, logic [7:0] s);
		check_count++;
		if (s !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic check48(string n, logic [47:0] e, logic [47:0] s);
		check_count++;
		if (s !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask

	// Watcher: read data one cycle after the strobe, pins when sampled
	always @(posedge clk) begin
		if (rd_d && rd_q.size() > 0)
			check8("rdata", rd_q.pop_front(), rdata);
		if (samp && pin_q.size() > 0)
			check48("pins", pin_q.pop_front(),
				{a_oe, a_lvl & a_oe, b_oe, b_lvl & b_oe});
		rd_d <= rd;
	end

	task automatic tick(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic wr_reg(logic [7:0] a, logic [7:0] d);
		addr = a;
		wdata = d;
		wr = 1'b1;
		tick(1);
		wr = 1'b0;
		// Idle edge so a following strobe is not raised in the same step
		tick(1);
	endtask

	task automatic rd_reg(logic [7:0] a, logic [7:0] e);
		addr = a;
		rd = 1'b1;
		rd_q.push_back(e);
		tick(1);
		rd = 1'b0;
		tick(1);
	endtask

	task automatic expect_pins(logic [47:0] e);
		pin_q.push_back(e);
		samp = 1'b1;
		tick(1);
		samp = 1'b0;
	endtask

	// Frame low while the 8 MHz clock rises marks the boundary
	task automatic boundary();
		c8 = 1'b0;
		frm_b = 1'b0;
		tick(1);
		c8 = 1'b1;
		tick(1);
		frm_b = 1'b1;
	endtask

	// Sample mid-way through tick position p; a tick is 65536/5368 cycles
	task automatic at_pos(int p, logic [11:0] boe, logic [11:0] a,
		logic [11:0] b);
		boundary();
		tick(3 + ((2 * p + 1) * 65536) / 10736);
		expect_pins({12'hfff, a, boe, b});
	endtask

	initial begin
		repeat (100000) @(posedge clk);
		mismatches++;
		give_verdict();
	end

	initial begin
		tick(12);
		rst_b = 1'b1;
		for (int a = 8'h20; a <= 8'h26; a++)
			rd_reg(8'(a), 8'h00);
		for (int a = 8'h20; a <= 8'h25; a++) begin
			r = 8'($random(seed));
			wr_reg(8'(a), r);
			rd_reg(8'(a), (a == 8'h25) ? (r & 8'hdf) : r);
		end
		wr_reg(8'h30, 8'h5a);
		rd_reg(8'h30, 8'h00);
		for (int i = 0; i < 3; i++) begin
			r = 8'($random(seed));
			h = {2'h1, 6'($random(seed))};
			pl = 8'($random(seed));
			pb = 8'($random(seed));
			wr_reg(8'h20, r);
			wr_reg(8'h21, h);
			wr_reg(8'h23, {2'h2, 6'($random(seed))});
			wr_reg(8'h24, pl);
			wr_reg(8'h25, {4'h5, pb[3:0]});
			tick(2);
			expect_pins({12'hfff, h[3:0], r, 12'hfff, pb[3:0], pl});
		end
		wr_reg(8'h21, {2'h0, h[5:0]});
		tick(2);
		expect_pins({24'h0, 12'hfff, pb[3:0], pl});
		wr_reg(8'h20, 8'h00);
		wr_reg(8'h21, 8'hc0);
		wr_reg(8'h23, 8'h00);
		wr_reg(8'h25, 8'h00);
		at_pos(1, 12'h000, 12'h001, 12'h000);
		at_pos(3, 12'h000, 12'h000, 12'h000);
		at_pos(17, 12'h000, 12'h002, 12'h000);
		wr_reg(8'h21, 8'hd0);
		at_pos(3, 12'h000, 12'h001, 12'h000);
		wr_reg(8'h21, 8'h80);
		at_pos(33, 12'h000, 12'h002, 12'h000);
		wr_reg(8'h21, 8'hc8);
		at_pos(1, 12'h000, 12'hffe, 12'h000);
		wr_reg(8'h21, 8'hf0);
		at_pos(17, 12'h000, 12'h003, 12'h000);
		at_pos(33, 12'h000, 12'h006, 12'h000);
		// B: start 0x105, 2 Mbit/s, byte-wide pulses, routed onto A 6-11
		wr_reg(8'h21, 8'hc0);
		wr_reg(8'h20, 8'h2a);
		wr_reg(8'h22, 8'h05);
		wr_reg(8'h23, 8'h61);
		wr_reg(8'h25, 8'h80);
		at_pos(260, 12'hfff, 12'h000, 12'h000);
		at_pos(463, 12'hfff, 12'h200, 12'h008);
		wr_reg(8'h25, 8'hc0);
		at_pos(463, 12'hfff, 12'h22a, 12'h008);
		tick(3);
		give_verdict();
	end
endmodule
